/* verilog/deewc_top.sv */
// Data EEPROM write controller: control/status register, row latches, program timer.
// Assumes an Avalon-MM master on SYS_CLK and power-mode requests synchronous to it.

module deewc_top
  import deewc_pkg::*;
#(
  parameter int PROG_CYC = deewc_pkg::PROG_CYCLES
) (
  // Clock and reset
  input  wire logic                           SYS_CLK,
  input  wire logic                           RESETN,
  // Avalon-MM slave
  input  wire logic [deewc_pkg::ADDR_W-1:0]   AVS_ADDRESS,
  input  wire logic                           AVS_READ,
  input  wire logic                           AVS_WRITE,
  input  wire logic [deewc_pkg::DATA_W-1:0]   AVS_WRITEDATA,
  input  wire logic [3:0]                     AVS_BYTEENABLE,
  output logic      [deewc_pkg::DATA_W-1:0]   AVS_READDATA,
  output logic                                AVS_WAITREQUEST,
  // Power and protection
  input  wire logic                           WAIT_REQ,
  input  wire logic                           HALT_REQ,
  input  wire logic                           PROTECT_OPT,
  // Status
  output logic                                BUS_DRIVEN,
  output logic                                EE_ASLEEP
);
  import deewc_pkg::*;

  localparam int CNT_W = $clog2(PROG_CYC + ARRAY_BYTES + 1);

  // Bus timing overview
  // Waitrequest idles high and drops for exactly one cycle per transfer.
  // Writes: one wait cycle; the store acts at the edge where waitrequest is low.
  // Acting at that edge, not the first one, keeps a held request from acting twice.
  // Reads: two wait cycles, one for the registered array read, one for the mux.
  // Read data are registered and stand until the next read answer.
  // Only byte lane 0 carries data; other lanes read back as zero.
  //
  // Programming cycle overview
  // The counter runs PROG_CYC clocks, standing in for the physical program time.
  // Erase and program phases are chained inside that single count.
  // The final ROW_BYTES clocks commit one latch per clock into the array.
  // Columns are visited 1..31 and then 0, on the very last clock.
  // Latches that were never stored keep the old cell value.
  // PROG_CYC must be at least ROW_BYTES plus one, or the commit window would wrap.
  //
  // Power modes
  // Wait defers until the running cycle has ended, then sleeps.
  // Halt drops the running cycle and the row latch valid bits at once; the row being written may be corrupt.
  // Both write-mode and start bits clear once halt is still high in sleep, so software sees idle.
  //
  // Protection
  // The option is sampled every clock; its falling edge in idle starts a wipe.
  // The wipe writes the erased value to every array byte, one per clock.
  // While protected, window reads are undriven and all stores are dropped.
  //
  // Reset
  // Reset aborts any cycle; the array is left as it stands, possibly half written.

  // Array memory with registered read data
  deewc_mem_if #(.AW(ARR_AW)) mem ();

  deewc_array #(.DEPTH(ARRAY_BYTES), .AW(ARR_AW)) u_array (
    .SYS_CLK (SYS_CLK),
    .m       (mem)
  );

  deewc_state_t               state_ff;
  logic                       lat_ff;
  logic                       pgm_ff;
  logic [7:0]                 latch_ff [ROW_BYTES];
  logic [ROW_BYTES-1:0]       lvalid_ff;
  logic [ARR_AW-COL_W-1:0]    row_ff;
  logic [CNT_W-1:0]           cnt_ff;
  logic [COL_W-1:0]           col_ff;
  logic                       prot_ff;
  logic                       erase_ff;
  logic                       rd_pend_ff;
  logic [DATA_W-1:0]          rdata_ff;
  logic                       wreq_ff;
  logic                       drv_ff;
  logic                       sleep_ff;

  // Bus decode
  logic       hit_csr;
  logic       hit_opt;
  logic       hit_win;
  logic       wr_csr;
  logic       wr_win;
  logic       rd_any;
  logic       prog_end;
  logic       lat_fall;
  logic [7:0] wbyte;

  function automatic logic [7:0] byte_of(input logic [DATA_W-1:0] d, input logic [3:0] be);
    logic [7:0] b;
    b = 8'hff;
    if (be[0]) begin
      b = d[7:0];
    end
    return b;
  endfunction

  assign hit_csr  = (AVS_ADDRESS == CSR_ADDR);
  assign hit_opt  = (AVS_ADDRESS == OPT_ADDR);
  assign hit_win  = ((AVS_ADDRESS & WIN_MASK) == WIN_BASE);
  // A write acts only at the edge where waitrequest is seen low
  assign wr_csr   = AVS_WRITE && !wreq_ff && hit_csr && AVS_BYTEENABLE[0];
  assign wr_win   = AVS_WRITE && !wreq_ff && hit_win && AVS_BYTEENABLE[0];
  assign rd_any   = AVS_READ && !rd_pend_ff && wreq_ff;
  assign wbyte    = byte_of(AVS_WRITEDATA, AVS_BYTEENABLE);
  assign prog_end = (state_ff == DEEWC_PROG) && (cnt_ff == CNT_W'(PROG_CYC - 1));
  assign lat_fall = wr_csr && lat_ff && !wbyte[LAT_BIT] && !pgm_ff;

  // Waitrequest: one wait cycle for writes, two for reads (array read latency)
  // A read raises rd_pend first; the answer follows one clock later.
  // After any answer waitrequest returns high, so a held request is never answered twice.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wreq_ff    <= 1'b1;
      rd_pend_ff <= 1'b0;
    end else begin
      if (AVS_WRITE && wreq_ff) begin
        wreq_ff <= 1'b0;
      end else if (rd_any) begin
        rd_pend_ff <= 1'b1;
      end else if (rd_pend_ff) begin
        rd_pend_ff <= 1'b0;
        wreq_ff    <= 1'b0;
      end else begin
        wreq_ff <= 1'b1;
      end
    end
  end

  // Protection option sampled every clock after reset release
  // The registered copy lets idle logic see the option's falling edge.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      prot_ff <= 1'b0;
    end else begin
      prot_ff <= PROTECT_OPT;
    end
  end

  // Control/status bits
  // End of cycle and halt in sleep both win over a software write in the same clock.
  // Software may clear write mode only while no cycle is pending.
  // The start flag sets only with write mode already set or set in the same store.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      lat_ff <= CSR_RESET[LAT_BIT];
      pgm_ff <= CSR_RESET[PGM_BIT];
    end else if (prog_end || state_ff == DEEWC_SLEEP && HALT_REQ) begin
      lat_ff <= 1'b0;
      pgm_ff <= 1'b0;
    end else if (wr_csr && !prot_ff && state_ff == DEEWC_IDLE) begin
      if (wbyte[LAT_BIT]) begin
        lat_ff <= 1'b1;
      end else if (!pgm_ff) begin
        lat_ff <= 1'b0;
      end
      if (wbyte[PGM_BIT] && (lat_ff || wbyte[LAT_BIT])) begin
        pgm_ff <= 1'b1;
      end
    end
  end

  // Row latches: AND-accumulate, cleared at end or write-mode fall
  // Valid bits mark which columns the next cycle will commit.
  // The row follows the most recent store; software keeps stores in one row.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      lvalid_ff <= '0;
      row_ff    <= '0;
    end else if (prog_end || lat_fall || HALT_REQ) begin
      lvalid_ff <= '0;
    end else if (wr_win && lat_ff && !pgm_ff && !prot_ff) begin
      lvalid_ff[AVS_ADDRESS[COL_W-1:0]] <= 1'b1;
      row_ff <= AVS_ADDRESS[ARR_AW-1:COL_W];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (wr_win && lat_ff && !pgm_ff && !prot_ff) begin
      if (lvalid_ff[AVS_ADDRESS[COL_W-1:0]]) begin
        latch_ff[AVS_ADDRESS[COL_W-1:0]] <= latch_ff[AVS_ADDRESS[COL_W-1:0]] & wbyte;
      end else begin
        latch_ff[AVS_ADDRESS[COL_W-1:0]] <= wbyte;
      end
    end
  end

  // Programming sequencer and power modes
  // Halt overrides every state; wait is taken only from idle or at cycle end.

  // Latch data have no reset; the valid bits guard every use of them
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff <= DEEWC_IDLE;
      cnt_ff   <= '0;
      erase_ff <= 1'b0;
    end else if (HALT_REQ) begin
      state_ff <= DEEWC_SLEEP;
      cnt_ff   <= '0;
    end else begin
      unique case (state_ff)
        DEEWC_IDLE: begin
          cnt_ff <= '0;
          if (prot_ff && !PROTECT_OPT) begin
            state_ff <= DEEWC_WIPE;
            erase_ff <= 1'b1;
          end else if (WAIT_REQ) begin
            state_ff <= DEEWC_SLEEP;
          end else if (pgm_ff) begin
            state_ff <= DEEWC_PROG;
          end
        end
        DEEWC_PROG: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (prog_end) begin
            state_ff <= WAIT_REQ ? DEEWC_SLEEP : DEEWC_IDLE;
          end
        end
        DEEWC_WIPE: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == CNT_W'(ARRAY_BYTES - 1)) begin
            state_ff <= DEEWC_IDLE;
            erase_ff <= 1'b0;
          end
        end
        DEEWC_SLEEP: begin
          if (!WAIT_REQ) begin
            state_ff <= DEEWC_IDLE;
          end
        end
      endcase
    end
  end

  // Commit one latched byte per clock during the final row of cycles
  // The column counter starts one clock early so that column 0 lands last.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      col_ff <= '0;
    end else if (state_ff == DEEWC_PROG && cnt_ff >= CNT_W'(PROG_CYC - ROW_BYTES - 1)) begin
      col_ff <= col_ff + 1'b1;
    end else begin
      col_ff <= '0;
    end
  end

  assign mem.we    = (erase_ff && state_ff == DEEWC_WIPE) ||
                     (state_ff == DEEWC_PROG && cnt_ff >= CNT_W'(PROG_CYC - ROW_BYTES) && lvalid_ff[col_ff]);
  assign mem.waddr = erase_ff ? cnt_ff[ARR_AW-1:0] : {row_ff, col_ff};
  assign mem.wdata = erase_ff ? ERASED_BYTE : latch_ff[col_ff];
  assign mem.raddr = AVS_ADDRESS[ARR_AW-1:0];

  // Array port: the wipe owns the write side while it runs
  // Read address follows the bus directly; the array registers the data.

  // Read data: latches have no path here
  // Undriven reads keep the data at zero and drop BUS_DRIVEN.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_ff <= UNMAPPED_DATA;
      drv_ff   <= 1'b0;
    end else if (rd_pend_ff) begin
      drv_ff   <= 1'b1;
      rdata_ff <= UNMAPPED_DATA;
      if (hit_csr) begin
        rdata_ff[7:0] <= {6'h00, lat_ff, pgm_ff};
      end else if (hit_opt) begin
        rdata_ff[7:0] <= {5'h00, erase_ff, state_ff == DEEWC_SLEEP, prot_ff};
      end else if (hit_win) begin
        if (lat_ff || prot_ff) begin
          drv_ff <= 1'b0;
        end else begin
          rdata_ff[7:0] <= mem.rdata;
        end
      end
    end
  end

  // Sleep status, registered so the output comes straight from a flip-flop
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sleep_ff <= 1'b0;
    end else begin
      sleep_ff <= (state_ff == DEEWC_SLEEP);
    end
  end

  assign AVS_READDATA    = rdata_ff;
  assign AVS_WAITREQUEST = wreq_ff;
  assign BUS_DRIVEN      = drv_ff;
  assign EE_ASLEEP       = sleep_ff;
endmodule

/* verilog/deewc_pkg.sv */
// Package for the data EEPROM write controller: register map, field layout, timing.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
package deewc_pkg;
  localparam int            ADDR_W          = 10;
  localparam int            DATA_W          = 32;
  localparam int            ROW_BYTES       = 32;
  localparam int            COL_W           = 5;
  localparam int            ARRAY_BYTES     = 256;
  localparam int            ARR_AW          = 8;
  // Byte addresses on the bus
  localparam logic [9:0]    CSR_ADDR        = 10'h020;
  localparam logic [9:0]    OPT_ADDR        = 10'h024;
  localparam logic [9:0]    WIN_BASE        = 10'h100;
  localparam logic [9:0]    WIN_MASK        = 10'h300;
  // Control/status fields
  localparam int            PGM_BIT         = 0;
  localparam int            LAT_BIT         = 1;
  localparam logic [7:0]    CSR_RESET       = 8'h00;
  // Option register fields
  localparam int            OPT_PROT_BIT    = 0;
  localparam int            STS_WAIT_BIT    = 1;
  localparam int            STS_ERASE_BIT   = 2;
  // Timing
  localparam int            CLK_MHZ         = 100;
  localparam int            PROG_TIME_US    = 5;
  localparam int            PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
  localparam logic [7:0]    ERASED_BYTE     = 8'hff;
  localparam logic [31:0]   UNMAPPED_DATA   = 32'h0000_0000;

  typedef enum logic [1:0] {
    DEEWC_IDLE  = 2'b00,
    DEEWC_PROG  = 2'b01,
    DEEWC_WIPE  = 2'b11,
    DEEWC_SLEEP = 2'b10
  } deewc_state_t;
endpackage

/* verilog/deewc_mem_if.sv */
// Interface between the controller and its array memory.
// Assumes a single clock shared by both ends.
interface deewc_mem_if #(parameter int AW = 8);
  logic          we;
  logic [AW-1:0] waddr;
  logic [7:0]    wdata;
  logic [AW-1:0] raddr;
  logic [7:0]    rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* verilog/deewc_array.sv */
// Byte-wide nonvolatile array model with registered read data.
// Assumes writes come one byte per clock from the controller.
module deewc_array #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  // Clock
  input wire logic SYS_CLK,
  // Array port
  deewc_mem_if.mem m
);
  logic [7:0] cell_ff [DEPTH];
  logic [7:0] rdata_ff;

  always_ff @(posedge SYS_CLK) begin
    if (m.we) begin
      cell_ff[m.waddr] <= m.wdata;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    rdata_ff <= cell_ff[m.raddr];
  end

  assign m.rdata = rdata_ff;
endmodule

/* tb/deewc_checker.sv */
// Port checker for the data EEPROM write controller.
// Assumes it is bound to deewc_top and sees only its ports.
module deewc_checker
  import deewc_pkg::*;
(
  // Clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RESETN,
  // Avalon-MM slave
  input wire logic [9:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  // Power and status
  input wire logic        HALT_REQ,
  input wire logic        EE_ASLEEP
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  logic csr_ans;
  assign csr_ans = AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == CSR_ADDR;
  sequence s_read_ans;
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
  endsequence
  property p_wr_ans;
    AVS_WRITE && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  property p_rd_ans;
    AVS_READ && AVS_WAITREQUEST && !$past(AVS_READ) |=> s_read_ans;
  endproperty
  property p_one_low;
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  property p_hi_zero;
    AVS_READDATA[31:8] == 24'h0;
  endproperty
  property p_csr_rsv;
    csr_ans |-> AVS_READDATA[7:2] == 6'h0;
  endproperty
  property p_pgm_lat;
    csr_ans && AVS_READDATA[PGM_BIT] |-> AVS_READDATA[LAT_BIT];
  endproperty
  property p_pgm_awake;
    csr_ans && AVS_READDATA[PGM_BIT] |-> !EE_ASLEEP;
  endproperty
  property p_halt;
    $rose(HALT_REQ) |-> ##[1:3] EE_ASLEEP;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  a_one_low: assert property (p_one_low) else $error("waitrequest low too long");
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  a_csr_rsv: assert property (p_csr_rsv) else $error("reserved bits set");
  a_pgm_lat: assert property (p_pgm_lat) else $error("start without write mode");
  a_pgm_awake: assert property (p_pgm_awake) else $error("asleep while programming");
  a_halt: assert property (p_halt) else $error("halt not entered");
endmodule

/* tb/tb.sv */
// Self-checking bench for the data EEPROM write controller.
// Assumes the package, interface, array and top are compiled first.
module tb
  import deewc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk  = 1'b0;
  logic        resetn   = 1'b0;
  logic [9:0]  addr     = 10'h0;
  logic        rd       = 1'b0;
  logic        wr       = 1'b0;
  logic [31:0] wdata    = 32'h0;
  logic        wait_req = 1'b0;
  logic        halt_req = 1'b0;
  logic        prot     = 1'b0;
  logic [31:0] rdata;
  logic [31:0] got;
  logic        wreq;
  logic        drv;
  logic        got_drv;
  logic        asleep;
  int          miscompares = 0;
  int          check_count = 0;
  int          cyc = 0;
  always #5 sys_clk = ~sys_clk;
  deewc_top #(.PROG_CYC(40)) i_deewc_top (
    .SYS_CLK(sys_clk), .RESETN(resetn), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
    .WAIT_REQ(wait_req), .HALT_REQ(halt_req), .PROTECT_OPT(prot), .BUS_DRIVEN(drv), .EE_ASLEEP(asleep));
  task automatic final_report();
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One bus cycle held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= {24'h0, d};
    wr    <= w;
    rd    <= !w;
    do @(posedge sys_clk); while (wreq !== 1'b0);
    got = rdata;
    wr  <= 1'b0;
    rd  <= 1'b0;
    @(posedge sys_clk);
    got_drv = drv;
  endtask
  task automatic rdchk(input string n, input logic [9:0] a, input logic [7:0] e, input logic de);
    bus(1'b0, a, 8'h0);
    chk({n, " drv"}, {31'h0, de}, {31'h0, got_drv});
    if (de) chk(n, {24'h0, e}, got);
  endtask
  task automatic poll_clear(input logic [9:0] a, input int b);
    do bus(1'b0, a, 8'h0); while (got[b] !== 1'b0);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    rdchk("csr reset", CSR_ADDR, 8'h00, 1'b1);
    rdchk("unmapped", 10'h3f0, 8'h00, 1'b1);
    bus(1'b1, CSR_ADDR, 8'hfe);
    rdchk("csr rsv", CSR_ADDR, 8'h02, 1'b1);
    bus(1'b1, 10'h140, 8'h5a);
    bus(1'b1, 10'h15f, 8'h81);
    bus(1'b1, 10'h140, 8'h3c);
    rdchk("wmode rd", 10'h140, 8'h00, 1'b0);
    bus(1'b1, CSR_ADDR, 8'h03);
    rdchk("csr busy", CSR_ADDR, 8'h03, 1'b1);
    bus(1'b1, CSR_ADDR, 8'h00);
    rdchk("csr hold", CSR_ADDR, 8'h03, 1'b1);
    poll_clear(CSR_ADDR, PGM_BIT);
    chk("csr done", 32'h0, got);
    rdchk("row b0", 10'h140, 8'h18, 1'b1);
    rdchk("row b31", 10'h15f, 8'h81, 1'b1);
    bus(1'b1, 10'h140, 8'h00);
    rdchk("ro store", 10'h140, 8'h18, 1'b1);
    bus(1'b1, CSR_ADDR, 8'h02);
    bus(1'b1, 10'h160, 8'h0f);
    bus(1'b1, CSR_ADDR, 8'h00);
    bus(1'b1, CSR_ADDR, 8'h02);
    bus(1'b1, 10'h160, 8'hf0);
    bus(1'b1, CSR_ADDR, 8'h03);
    poll_clear(CSR_ADDR, PGM_BIT);
    rdchk("lat fall", 10'h160, 8'hf0, 1'b1);
    bus(1'b1, CSR_ADDR, 8'h02);
    bus(1'b1, 10'h161, 8'h55);
    bus(1'b1, CSR_ADDR, 8'h03);
    wait_req <= 1'b1;
    @(posedge sys_clk);
    chk("wait busy", 32'h0, {31'h0, asleep});
    repeat (60) @(posedge sys_clk);
    chk("wait idle", 32'h1, {31'h0, asleep});
    wait_req <= 1'b0;
    rdchk("wait prog", 10'h161, 8'h55, 1'b1);
    bus(1'b1, CSR_ADDR, 8'h02);
    bus(1'b1, 10'h162, 8'h11);
    bus(1'b1, CSR_ADDR, 8'h03);
    halt_req <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("halt", 32'h1, {31'h0, asleep});
    halt_req <= 1'b0;
    rdchk("csr halt", CSR_ADDR, 8'h00, 1'b1);
    prot <= 1'b1;
    rdchk("prot rd", 10'h140, 8'h00, 1'b0);
    bus(1'b1, CSR_ADDR, 8'h02);
    rdchk("prot csr", CSR_ADDR, 8'h00, 1'b1);
    prot <= 1'b0;
    poll_clear(OPT_ADDR, STS_ERASE_BIT);
    rdchk("erased", 10'h140, ERASED_BYTE, 1'b1);
    bus(1'b1, CSR_ADDR, 8'h02);
    bus(1'b1, 10'h163, 8'h22);
    bus(1'b1, CSR_ADDR, 8'h03);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rdchk("csr abort", CSR_ADDR, 8'h00, 1'b1);
    final_report();
  end
endmodule

bind deewc_top deewc_checker i_deewc_checker (
  .SYS_CLK, .RESETN, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST,
  .HALT_REQ, .EE_ASLEEP);
